// >>> sbp_pkg.sv
/*
 * Shared constants and types for the SDRAM bank-close and power-state
 * pair: command encodings, power states and timing counts. Assumes a
 * single 125 MHz clock shared by both ends.
 */
// Function
// - precharge: cs ras we low, cas high
// - precharge-all bit high closes every bank
// - activate a precharged bank before access
// - precharge time before next activate
// - self refresh entry with previous cke high
// - self refresh only with all banks idle
// - self refresh holds while cke low
// - internal clock gated in self refresh
// - wait access plus exit time after exit
// - refresh burst around self refresh advised
// - refresh cycle time after auto refresh
// - power down on cke low with nop/deselect
// - cke low in burst gives clock suspend
// - leave power down within refresh period
// - exit power down with nop, hold cke
// - nop decoded, does not end bursts
// - deselect ignores strobes, acts as nop
// - clock suspend when cke low, bank active; code suspends only in a burst or on a command other than nop/deselect
// - suspend and resume lag one clock
// - decode uses previous cke level
// - activate read write mode refresh encodings
// - burst stop valid only in full page
// - precharge-all bit on access: auto precharge
package sbp_pkg;
    // ------------------------------------------------------------------
    // commands, as {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_MODE_SET = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    localparam logic [3:0] CMD_DESELECT = 4'hf;
    localparam int NUM_BANKS = 4;
    localparam int BURST_LEN = 4;
    // ------------------------------------------------------------------
    // timing in ns and in cycles of the 8 ns clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int PRECHARGE_TIME_NS = 15;
    localparam int REFRESH_CYCLE_TIME_NS = 60;
    localparam int ACCESS_CYCLE_TIME_NS = 6;
    localparam int SELF_REFRESH_EXIT_NS = 60;
    localparam int CLOCK_ENABLE_SETUP_NS = 2;
    localparam int PRECHARGE_CYC =
        (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_CYC =
        (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_EXIT_CYC = (ACCESS_CYCLE_TIME_NS
        + SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKE_HOLD_CYC = (CLOCK_ENABLE_SETUP_NS
        + CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_PERIOD_MS = 64;
    localparam int POWER_DOWN_MAX_CYC = 65536;
    // ------------------------------------------------------------------
    // power states of the device end
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SBP_NORMAL = 3'b000,
        SBP_SELF_REFRESH = 3'b001,
        SBP_POWER_DOWN = 3'b010,
        SBP_SUSPEND = 3'b011
    } sbp_power_t;
    // host request codes
    typedef enum logic [2:0] {
        SBP_REQ_ACTIVATE = 3'b000,
        SBP_REQ_READ = 3'b001,
        SBP_REQ_WRITE = 3'b010,
        SBP_REQ_PRECHARGE = 3'b011,
        SBP_REQ_REFRESH = 3'b100,
        SBP_REQ_SELF_REFRESH = 3'b101,
        SBP_REQ_POWER_DOWN = 3'b110,
        SBP_REQ_BURST_STOP = 3'b111
    } sbp_req_t;
endpackage

// >>> sbp_if.sv
/*
 * Pin bundle between the memory controller and the SDRAM command end.
 * Assumes both ends share clk; no reset pin reaches the device.
 */
`timescale 1ns/100ps
interface sbp_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_select;
    logic precharge_all_select;
    logic dqm;
    modport host (output cke, cs_n, ras_n, cas_n, we_n, bank_select,
        precharge_all_select, dqm);
    modport device (input cke, cs_n, ras_n, cas_n, we_n, bank_select,
        precharge_all_select, dqm);
endinterface

// >>> sbp_device.sv
/*
 * Device end: decodes commands on the strobes, tracks open banks, a
 * simple burst counter and the power states. Assumes the controller
 * keeps its timing duties; pins arrive on clk from logic on clk.
 */
`timescale 1ns/100ps
module sbp_device #(
    parameter int BURST_LEN = sbp_pkg::BURST_LEN
) (
    input wire logic clk,
    input wire logic reset_n,
    sbp_if.device pins,
    output logic [3:0] bank_open,
    output sbp_pkg::sbp_power_t power_state,
    output logic internal_clk_en,
    output logic receivers_on,
    output logic burst_active,
    output logic data_enable,
    output logic [3:0] auto_precharge_pending,
    output logic mode_set_seen
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic cke_prev;
    logic [3:0] cmd;
    logic [7:0] burst_cnt;
    logic [1:0] burst_bank;
    logic full_page;
    wire normal = power_state == sbp_pkg::SBP_NORMAL;
    wire live = normal && cke_prev;
    assign cmd = pins.cs_n ? sbp_pkg::CMD_DESELECT
        : {1'b0, pins.ras_n, pins.cas_n, pins.we_n};
    wire is_act = live && cmd == sbp_pkg::CMD_ACTIVATE;
    wire is_rd = live && pins.cke && cmd == sbp_pkg::CMD_READ;
    wire is_wr = live && pins.cke && cmd == sbp_pkg::CMD_WRITE;
    wire is_pre = live && pins.cke && cmd == sbp_pkg::CMD_PRECHARGE;
    wire is_mrs = live && cmd == sbp_pkg::CMD_MODE_SET;
    wire is_idle_cmd = cmd == sbp_pkg::CMD_NOP
        || cmd == sbp_pkg::CMD_DESELECT;
    wire is_sr = live && !pins.cke
        && cmd == sbp_pkg::CMD_REFRESH && bank_open == 4'h0;
    wire is_stop = live && cmd == sbp_pkg::CMD_BURST_STOP
        && burst_active && full_page;
    wire cke_low = live && !pins.cke && !is_sr;
    wire to_suspend = cke_low && (burst_active || bank_open != 4'h0
        && !is_idle_cmd);
    wire to_pd = cke_low && !to_suspend && is_idle_cmd;
    wire [3:0] bank_bit = 4'h1 << {pins.bank_select};
    wire [3:0] pre_mask = pins.precharge_all_select ? 4'hf
        : bank_bit;
    wire burst_done = burst_active && !full_page && burst_cnt == 8'h1;
    wire [3:0] ap_close = burst_done ? auto_precharge_pending
        & (4'h1 << {burst_bank}) : 4'h0;
    // ------------------------------------------------------------------
    // power state; exits take effect one clock after cke rises
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            power_state <= sbp_pkg::SBP_NORMAL;
        end else begin
            unique case (power_state)
                sbp_pkg::SBP_NORMAL: begin
                    if (is_sr) begin
                        power_state <= sbp_pkg::SBP_SELF_REFRESH;
                    end else if (to_suspend) begin
                        power_state <= sbp_pkg::SBP_SUSPEND;
                    end else if (to_pd) begin
                        power_state <= sbp_pkg::SBP_POWER_DOWN;
                    end
                end
                default: begin
                    if (pins.cke) begin
                        power_state <= sbp_pkg::SBP_NORMAL;
                    end
                end
            endcase
        end
    end
    // clock gating view; ops freeze the clock after cke registers low
    assign internal_clk_en = normal;
    assign receivers_on = normal
        || power_state == sbp_pkg::SBP_SUSPEND;
    // ------------------------------------------------------------------
    // previous cke level, always sampled so exits are seen
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cke_prev <= 1'b0;
        end else begin
            cke_prev <= pins.cke;
        end
    end
    // ------------------------------------------------------------------
    // bank table and auto precharge flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bank_open <= 4'h0;
            auto_precharge_pending <= 4'h0;
        end else if (internal_clk_en) begin
            if (is_pre) begin
                bank_open <= bank_open & ~pre_mask & ~ap_close;
            end else if (is_act) begin
                bank_open <= (bank_open | bank_bit) & ~ap_close;
            end else begin
                bank_open <= bank_open & ~ap_close;
            end
            if (is_rd || is_wr) begin
                auto_precharge_pending <= (auto_precharge_pending
                    & ~ap_close) | (pins.precharge_all_select
                    && !full_page ? bank_bit : 4'h0);
            end else begin
                auto_precharge_pending <= auto_precharge_pending
                    & ~ap_close;
            end
        end
    end
    // ------------------------------------------------------------------
    // burst counter; frozen while suspended, nop keeps it running
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            burst_active <= 1'b0;
            burst_cnt <= 8'h0;
            burst_bank <= 2'h0;
            full_page <= 1'b0;
            mode_set_seen <= 1'b0;
        end else if (internal_clk_en) begin
            if (is_mrs) begin
                mode_set_seen <= 1'b1;
                full_page <= pins.precharge_all_select;
            end
            if ((is_rd || is_wr) && bank_open[pins.bank_select]) begin
                burst_active <= 1'b1;
                burst_cnt <= 8'(BURST_LEN);
                burst_bank <= pins.bank_select;
            end else if (is_stop || is_pre || burst_done) begin
                burst_active <= 1'b0;
            end else if (burst_active && !full_page) begin
                burst_cnt <= burst_cnt - 8'h1;
            end
        end
    end
    // data mask sampled each cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_enable <= 1'b0;
        end else begin
            data_enable <= bank_open != 4'h0 && !pins.dqm;
        end
    end
endmodule

// >>> sbp_host.sv
/*
 * Controller end: turns one-cycle requests into strobe patterns and
 * keeps the spacing the device expects. Assumes requests come from
 * logic on clk; busy stalls further requests.
 */
`timescale 1ns/100ps
module sbp_host #(
    parameter int POWER_DOWN_MAX = sbp_pkg::POWER_DOWN_MAX_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    sbp_if.host pins,
    input wire logic req_valid,
    input wire sbp_pkg::sbp_req_t req_code,
    input wire logic [1:0] req_bank,
    input wire logic req_all,
    input wire logic req_wake,
    input wire logic req_dqm,
    output logic busy,
    output logic asleep
);
    logic [3:0] open;
    logic [16:0] wait_cnt;
    logic [16:0] pd_cnt;
    logic [3:0] strobes;
    logic cke;
    // set only while asleep in self refresh, so the watchdog leaves it be
    logic sr_mode;
    wire go = req_valid && !busy;
    wire is_sr = req_code == sbp_pkg::SBP_REQ_SELF_REFRESH;
    wire is_pd = req_code == sbp_pkg::SBP_REQ_POWER_DOWN;
    wire pd_over = !cke && pd_cnt == 17'(POWER_DOWN_MAX);
    wire wake = asleep && (req_wake || pd_over);
    // ------------------------------------------------------------------
    // request to strobe pattern
    // ------------------------------------------------------------------
    function automatic logic [3:0] enc(input sbp_pkg::sbp_req_t c);
        unique case (c)
            sbp_pkg::SBP_REQ_ACTIVATE: enc = sbp_pkg::CMD_ACTIVATE;
            sbp_pkg::SBP_REQ_READ: enc = sbp_pkg::CMD_READ;
            sbp_pkg::SBP_REQ_WRITE: enc = sbp_pkg::CMD_WRITE;
            sbp_pkg::SBP_REQ_PRECHARGE: enc = sbp_pkg::CMD_PRECHARGE;
            sbp_pkg::SBP_REQ_REFRESH: enc = sbp_pkg::CMD_REFRESH;
            sbp_pkg::SBP_REQ_SELF_REFRESH: enc = sbp_pkg::CMD_REFRESH;
            sbp_pkg::SBP_REQ_POWER_DOWN: enc = sbp_pkg::CMD_DESELECT;
            sbp_pkg::SBP_REQ_BURST_STOP: enc = sbp_pkg::CMD_BURST_STOP;
        endcase
    endfunction
    // accesses to closed banks, and self refresh with open banks, drop
    wire legal = go && !asleep && ((req_code != sbp_pkg::SBP_REQ_READ
        && req_code != sbp_pkg::SBP_REQ_WRITE) || open[req_bank])
        && (!is_sr || open == 4'h0);
    assign pins.cs_n = strobes[3];
    assign pins.ras_n = strobes[2];
    assign pins.cas_n = strobes[1];
    assign pins.we_n = strobes[0];
    assign pins.cke = cke;
    // ------------------------------------------------------------------
    // issue; wait counts give precharge, refresh and exit spacing
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strobes <= sbp_pkg::CMD_NOP;
            cke <= 1'b1;
            asleep <= 1'b0;
            sr_mode <= 1'b0;
            wait_cnt <= 17'h0;
            open <= 4'h0;
            pins.bank_select <= 2'h0;
            pins.precharge_all_select <= 1'b0;
            pins.dqm <= 1'b1;
        end else begin
            pins.dqm <= req_dqm;
            strobes <= sbp_pkg::CMD_NOP;
            if (wait_cnt != 17'h0) begin
                wait_cnt <= wait_cnt - 17'h1;
            end
            if (wake) begin
                cke <= 1'b1;
                asleep <= 1'b0;
                sr_mode <= 1'b0;
                wait_cnt <= 17'(sbp_pkg::SR_EXIT_CYC
                    + sbp_pkg::CKE_HOLD_CYC);
            end else if (legal) begin
                strobes <= enc(req_code);
                pins.bank_select <= req_bank;
                pins.precharge_all_select <= req_all;
                if (is_sr || is_pd) begin
                    cke <= 1'b0;
                    asleep <= 1'b1;
                    sr_mode <= is_sr;
                end
                unique case (req_code)
                    sbp_pkg::SBP_REQ_PRECHARGE: begin
                        open <= open & ~(req_all ? 4'hf
                            : 4'h1 << {req_bank});
                        wait_cnt <= 17'(sbp_pkg::PRECHARGE_CYC);
                    end
                    sbp_pkg::SBP_REQ_ACTIVATE: begin
                        open <= open | 4'h1 << {req_bank};
                    end
                    sbp_pkg::SBP_REQ_REFRESH: begin
                        wait_cnt <= 17'(sbp_pkg::REFRESH_CYC);
                    end
                    default: begin
                        wait_cnt <= 17'h0;
                    end
                endcase
            end
        end
    end
    // power down duration watchdog
    always_ff @(posedge clk) begin
        if (!reset_n || cke || sr_mode) begin
            pd_cnt <= 17'h0;
        end else if (!pd_over) begin
            pd_cnt <= pd_cnt + 17'h1;
        end
    end
    assign busy = wait_cnt != 17'h0;
endmodule

// >>> sbp_pins_sva.sv
/*
 * Checker on the pins between controller end and device end.
 * Assumes it is instantiated beside the interface, on the one clock.
 */
`timescale 1ns/100ps
module sbp_pins_sva #(
    parameter int POWER_DOWN_MAX = sbp_pkg::POWER_DOWN_MAX_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank_select,
    input wire logic precharge_all_select,
    input wire logic dqm
);
    localparam int PRE_GAP = sbp_pkg::PRECHARGE_CYC;
    localparam int REF_GAP = sbp_pkg::REFRESH_CYC;
    localparam int SR_GAP = sbp_pkg::SR_EXIT_CYC;
    localparam int PD_LIMIT = POWER_DOWN_MAX + 4;
    // ----------------------------------------------------------------
    // decode of the strobes
    // ----------------------------------------------------------------
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire is_idle = cs_n || (cmd == sbp_pkg::CMD_NOP);
    wire is_act = cmd == sbp_pkg::CMD_ACTIVATE;
    wire is_pre = cmd == sbp_pkg::CMD_PRECHARGE;
    wire is_rw = (cmd == sbp_pkg::CMD_READ) || (cmd == sbp_pkg::CMD_WRITE);
    wire is_ref = cmd == sbp_pkg::CMD_REFRESH;
    wire is_sre = is_ref && !cke;
    logic cke_q;
    logic in_sr;
    logic [4:0] pre_gap;
    logic [4:0] ref_gap;
    logic [4:0] sr_gap;
    logic [3:0] open_banks;
    logic [17:0] low_cnt;
    // distance counters saturate so a long idle never wraps to a small gap
    always_ff @(posedge clk) begin
        cke_q <= cke;
        if (!reset_n) begin
            in_sr <= 1'b0;
            pre_gap <= '1;
            ref_gap <= '1;
            sr_gap <= '1;
            low_cnt <= '0;
        end else begin
            in_sr <= is_sre || (in_sr && !cke);
            pre_gap <= is_pre ? 5'h1 : pre_gap + {4'h0, pre_gap != '1};
            ref_gap <= (is_ref && cke) ? 5'h1
                : ref_gap + {4'h0, ref_gap != '1};
            sr_gap <= (in_sr && cke) ? 5'h1 : sr_gap + {4'h0, sr_gap != '1};
            low_cnt <= (!cke && !in_sr && !is_sre) ? low_cnt + 18'h1 : '0;
        end
    end
    // open banks as seen on the wire; auto precharge counts as closed at once
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            open_banks <= '0;
        end else if (cke_q && is_act) begin
            open_banks[bank_select] <= 1'b1;
        end else if (cke_q && is_pre && precharge_all_select) begin
            open_banks <= '0;
        end else if (cke_q && (is_pre
                || (is_rw && precharge_all_select))) begin
            open_banks[bank_select] <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_precharge_to_activate: assert property (
        is_act |-> pre_gap >= PRE_GAP)
        else $error("activate too soon after precharge");
    a_refresh_cycle_gap: assert property (
        !is_idle |-> ref_gap >= REF_GAP)
        else $error("command too soon after auto refresh");
    a_self_refresh_exit: assert property (
        !is_idle |-> sr_gap >= SR_GAP)
        else $error("command too soon after self refresh exit");
    a_wake_with_nop: assert property (
        $rose(cke) |-> is_idle)
        else $error("clock enable rose without nop or deselect");
    a_wake_cke_hold: assert property (
        $rose(cke) |-> cke [*2])
        else $error("clock enable not held after wake");
    a_sr_prev_cke: assert property (
        is_sre |-> cke_q)
        else $error("self refresh entry without clock enable high before");
    a_sr_banks_idle: assert property (
        is_sre |-> open_banks == 4'h0)
        else $error("self refresh entry with an open bank");
    a_access_open_bank: assert property (
        is_rw |-> open_banks[bank_select])
        else $error("access to a closed bank");
    a_power_down_bound: assert property (
        low_cnt <= PD_LIMIT)
        else $error("power down held too long");
    c_self_refresh: cover property (is_sre);
    c_wake: cover property ($rose(cke));
    c_precharge_all: cover property (is_pre && precharge_all_select);
endmodule

// >>> tb_sdram_bank_close_and_power_states.sv
/*
 * Testbench: host requests in, device state out, checker on the pins.
 * Assumes both ends run on one 125 MHz clock with synchronous reset.
 */
`timescale 1ns/100ps
module tb_sdram_bank_close_and_power_states;
    localparam int PD_MAX = 16;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    sbp_pkg::sbp_req_t req_code = sbp_pkg::SBP_REQ_ACTIVATE;
    logic [1:0] req_bank = 2'h0;
    logic req_all = 1'b0;
    logic req_wake = 1'b0;
    logic req_dqm = 1'b0;
    logic busy, asleep, internal_clk_en, receivers_on, burst_active;
    logic data_enable, mode_set_seen;
    logic [3:0] bank_open, auto_precharge_pending;
    sbp_pkg::sbp_power_t power_state;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    sbp_if i_sbp_if ();
    sbp_host #(.POWER_DOWN_MAX(PD_MAX)) i_sbp_host (.clk(clk),
        .reset_n(reset_n), .pins(i_sbp_if.host), .req_valid(req_valid),
        .req_code(req_code), .req_bank(req_bank), .req_all(req_all),
        .req_wake(req_wake), .req_dqm(req_dqm), .busy(busy),
        .asleep(asleep));
    sbp_device i_sbp_device (.clk(clk), .reset_n(reset_n),
        .pins(i_sbp_if.device), .bank_open(bank_open),
        .power_state(power_state), .internal_clk_en(internal_clk_en),
        .receivers_on(receivers_on), .burst_active(burst_active),
        .data_enable(data_enable),
        .auto_precharge_pending(auto_precharge_pending),
        .mode_set_seen(mode_set_seen));
    sbp_pins_sva #(.POWER_DOWN_MAX(PD_MAX)) i_sbp_pins_sva (.clk(clk),
        .reset_n(reset_n), .cke(i_sbp_if.cke), .cs_n(i_sbp_if.cs_n),
        .ras_n(i_sbp_if.ras_n), .cas_n(i_sbp_if.cas_n),
        .we_n(i_sbp_if.we_n), .bank_select(i_sbp_if.bank_select),
        .precharge_all_select(i_sbp_if.precharge_all_select),
        .dqm(i_sbp_if.dqm));
    // ----------------------------------------------------------------
    // clock, hang limit and shared tasks
    // ----------------------------------------------------------------
    always #4 clk = ~clk;
    // a hung wait counts as a mismatch and still ends in the one report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // inputs always move 1 ns after the edge, away from sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("Error at %0t: expected %h got %h", $time, exp, got);
            num_errors++;
        end
    endtask
    task automatic req(input sbp_pkg::sbp_req_t code, input logic [1:0] bank,
        input logic all);
        int n = 0;
        while (busy !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        req_valid = 1'b1;
        req_code = code;
        req_bank = bank;
        req_all = all;
        tick(1);
        req_valid = 1'b0;
    endtask
    task automatic wake();
        req_wake = 1'b1;
        tick(1);
        req_wake = 1'b0;
    endtask
    task automatic wait_ps(input sbp_pkg::sbp_power_t exp);
        int n = 0;
        while (power_state !== exp && n < 100) begin
            tick(1);
            n++;
        end
        chk({5'h0, exp}, {5'h0, power_state});
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(5);
        reset_n = 1'b1;
        tick(2);
        for (int b = 0; b < 4; b++)
            req(sbp_pkg::SBP_REQ_ACTIVATE, 2'(b), 1'b0);
        tick(2);
        chk(8'h0f, {4'h0, bank_open});
        req(sbp_pkg::SBP_REQ_PRECHARGE, 2'h2, 1'b0);
        tick(2);
        chk(8'h0b, {4'h0, bank_open});
        req(sbp_pkg::SBP_REQ_PRECHARGE, 2'h0, 1'b1);
        tick(2);
        chk(8'h00, {4'h0, bank_open});
        $display("test precharge ended at %0t", $time);
        req(sbp_pkg::SBP_REQ_READ, 2'h1, 1'b0);
        tick(2);
        chk(8'h00, {7'h0, burst_active});
        req(sbp_pkg::SBP_REQ_ACTIVATE, 2'h1, 1'b0);
        req(sbp_pkg::SBP_REQ_READ, 2'h1, 1'b1);
        tick(2);
        chk(8'h01, {7'h0, burst_active});
        chk(8'h02, {4'h0, auto_precharge_pending});
        req(sbp_pkg::SBP_REQ_BURST_STOP, 2'h1, 1'b0);
        tick(1);
        chk(8'h01, {7'h0, burst_active});
        tick(12);
        chk(8'h00, {4'h0, bank_open});
        req(sbp_pkg::SBP_REQ_ACTIVATE, 2'h0, 1'b0);
        req_dqm = 1'b1;
        tick(3);
        chk(8'h00, {7'h0, data_enable});
        req_dqm = 1'b0;
        tick(3);
        chk(8'h01, {7'h0, data_enable});
        $display("test access ended at %0t", $time);
        req(sbp_pkg::SBP_REQ_POWER_DOWN, 2'h0, 1'b0);
        wait_ps(sbp_pkg::SBP_POWER_DOWN);
        chk(8'h00, {7'h0, receivers_on});
        wake();
        wait_ps(sbp_pkg::SBP_NORMAL);
        req(sbp_pkg::SBP_REQ_READ, 2'h0, 1'b0);
        req(sbp_pkg::SBP_REQ_POWER_DOWN, 2'h0, 1'b0);
        wait_ps(sbp_pkg::SBP_SUSPEND);
        chk(8'h00, {7'h0, internal_clk_en});
        chk(8'h01, {7'h0, burst_active});
        wake();
        wait_ps(sbp_pkg::SBP_NORMAL);
        $display("test power down ended at %0t", $time);
        req(sbp_pkg::SBP_REQ_SELF_REFRESH, 2'h0, 1'b0);
        tick(4);
        chk(8'h00, {5'h0, power_state});
        req(sbp_pkg::SBP_REQ_PRECHARGE, 2'h0, 1'b1);
        req(sbp_pkg::SBP_REQ_REFRESH, 2'h0, 1'b0);
        req(sbp_pkg::SBP_REQ_SELF_REFRESH, 2'h0, 1'b0);
        wait_ps(sbp_pkg::SBP_SELF_REFRESH);
        chk(8'h00, {7'h0, internal_clk_en});
        chk(8'h01, {7'h0, asleep});
        req(sbp_pkg::SBP_REQ_ACTIVATE, 2'h2, 1'b0);
        tick(3);
        chk(8'h00, {4'h0, bank_open});
        wake();
        wait_ps(sbp_pkg::SBP_NORMAL);
        req(sbp_pkg::SBP_REQ_ACTIVATE, 2'h2, 1'b0);
        tick(2);
        chk(8'h04, {4'h0, bank_open});
        $display("test self refresh ended at %0t", $time);
        req(sbp_pkg::SBP_REQ_PRECHARGE, 2'h0, 1'b1);
        req(sbp_pkg::SBP_REQ_POWER_DOWN, 2'h0, 1'b0);
        wait_ps(sbp_pkg::SBP_POWER_DOWN);
        wait_ps(sbp_pkg::SBP_NORMAL);
        chk(8'h00, {7'h0, asleep});
        chk(8'h00, {7'h0, mode_set_seen});
        $display("test power down limit ended at %0t", $time);
        close_out();
    end
endmodule
